// ==== ssf_pkg.sv ====
// Constants shared by the serial status flag block.
// Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
package ssf_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] SSF_OFS_STATUS = 8'h00;
    localparam logic [7:0] SSF_OFS_CONTROL = 8'h04;
    localparam logic [7:0] SSF_OFS_RX_BUF = 8'h08;
    localparam logic [7:0] SSF_OFS_TX_BUF = 8'h0C;
    localparam logic [7:0] SSF_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SSF_OFS_IRQ_MASK = 8'h14;

    // ****************************************************************
    // Status field positions and reset value
    // ****************************************************************
    localparam int SSF_NUM_FLAGS = 5;
    localparam int SSF_TXE_IDX = 0;
    localparam int SSF_RXF_IDX = 1;
    localparam int SSF_OVR_IDX = 2;
    localparam int SSF_FRM_IDX = 3;
    localparam int SSF_PAR_IDX = 4;
    localparam int SSF_TEND_BIT = 2;
    localparam int SSF_FLAG_BIT [SSF_NUM_FLAGS] = '{7, 6, 5, 4, 3};
    localparam logic SSF_FLAG_RST [SSF_NUM_FLAGS] =
        '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    localparam logic SSF_TEND_RST = 1'b1;
    localparam logic [7:0] SSF_STATUS_RST = 8'h84;

    // ****************************************************************
    // Control field positions and reset value
    // ****************************************************************
    localparam int SSF_CTL_SYNC_BIT = 7;
    localparam int SSF_CTL_TXEN_BIT = 5;
    localparam int SSF_CTL_RXEN_BIT = 4;
    localparam int SSF_CTL_TWO_STOP_BIT = 3;
    localparam logic [7:0] SSF_CONTROL_RST = 8'h00;
    localparam logic [7:0] SSF_IRQ_RST = 8'h00;

    // ****************************************************************
    // AHB-Lite encodings
    // ****************************************************************
    localparam logic SSF_HRESP_OKAY = 1'b0;

endpackage : ssf_pkg

// ==== ssf_flag_cell.sv ====
// One software-clearable status flag with set priority.
// Assumes the caller decodes status reads and status writes.
`timescale 1ns/1ps
module ssf_flag_cell
    import ssf_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Hardware events
    input wire logic init,
    input wire logic set,
    input wire logic hw_clr,
    // Software accesses
    input wire logic rd_seen,
    input wire logic wr_any,
    input wire logic wr_zero,
    // Flag state
    output logic flag,
    output logic set_evt
);

    logic armed_reg;

    // ****************************************************************
    // Read-then-write-zero arming
    // ****************************************************************
    // Armed by a read that saw the flag at 1, spent by any status write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_reg <= 1'b0;
        end else if (init || wr_any) begin
            armed_reg <= 1'b0;
        end else if (rd_seen && flag) begin
            armed_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Flag state
    // ****************************************************************
    // Set wins over hw_clr and a software clear in the same cycle; init wins over set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag <= RST_VAL;
        end else if (init) begin
            flag <= RST_VAL;
        end else if (set) begin
            flag <= 1'b1;
        end else if (hw_clr || (wr_zero && armed_reg)) begin
            flag <= 1'b0;
        end
    end

    // Rising-edge event for the interrupt status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            set_evt <= 1'b0;
        end else begin
            set_evt <= set && !flag && !init;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_set_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        set && !init |=> flag)
        else $error("flag set lost against a clear");

    chk_no_sw_set: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !flag && !set && !init |=> !flag)
        else $error("flag rose without a hardware set");

    chk_unarmed_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag && !armed_reg && !hw_clr && !init |=> flag)
        else $error("flag cleared without prior read");

endmodule : ssf_flag_cell

// ==== ssf_status_flags.sv ====
// Serial port status flags with an AHB-Lite register slave.
// Assumes the shift logic reports events as one-cycle pulses on hclk.
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module ssf_status_flags
    import ssf_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Power management
    input wire logic low_power_mode,
    // Receiver events
    input wire logic rx_done,
    input wire logic [DATA_W-1:0] rx_char,
    input wire logic rx_frame_err,
    input wire logic rx_parity_err,
    // Transmitter events
    input wire logic tx_load,
    input wire logic tx_last_bit,
    // Shift logic control
    output logic [DATA_W-1:0] tx_char,
    output logic transmit_enable,
    output logic receive_enable,
    output logic sync_mode,
    output logic two_stop,
    output logic rx_halt,
    output logic tx_halt,
    // Interrupt
    output logic irq
);

    logic [7:0] control_reg, irq_stat_reg, irq_mask_reg, wr_addr_reg;
    logic [7:0] status, evt_vec;
    logic [DATA_W-1:0] rx_buffer_reg;
    logic tend_reg, wr_pend_reg;
    logic [31:0] rd_next;
    logic [SSF_NUM_FLAGS-1:0] flag, flag_set, flag_clr, flag_evt, wr_zero;
    logic ap_valid, rd_status, rd_rx, wr_status, wr_tx, wr_ctl;
    logic halt_now, tx_stop_now, rx_take, ovr, err_rx, good_rx, tx_go;

    // ****************************************************************
    // AHB-Lite decode
    // ****************************************************************
    // Address phase taken when selected, non-idle and bus ready
    assign ap_valid = hsel && htrans[1] && hready;
    assign rd_status = ap_valid && !hwrite && haddr[7:0] == SSF_OFS_STATUS;
    assign rd_rx = ap_valid && !hwrite && haddr[7:0] == SSF_OFS_RX_BUF;
    assign wr_status = wr_pend_reg && wr_addr_reg == SSF_OFS_STATUS;
    assign wr_tx = wr_pend_reg && wr_addr_reg == SSF_OFS_TX_BUF;
    assign wr_ctl = wr_pend_reg && wr_addr_reg == SSF_OFS_CONTROL;

    // Write address held into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= ap_valid && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Read data mux; unmapped offsets read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (haddr[7:0])
            SSF_OFS_STATUS: rd_next[7:0] = status;
            SSF_OFS_CONTROL: rd_next[7:0] = control_reg;
            SSF_OFS_RX_BUF: rd_next[DATA_W-1:0] = rx_buffer_reg;
            SSF_OFS_TX_BUF: rd_next[DATA_W-1:0] = tx_char;
            SSF_OFS_IRQ_STAT: rd_next[7:0] = irq_stat_reg;
            SSF_OFS_IRQ_MASK: rd_next[7:0] = irq_mask_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Zero-wait answer, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= SSF_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= SSF_HRESP_OKAY;
            if (ap_valid && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    // Control register steers enables, mode and stop bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= SSF_CONTROL_RST;
        end else if (wr_ctl) begin
            control_reg <= hwdata[7:0];
        end
    end

    // Transmit buffer written by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_char <= '0;
        end else if (wr_tx) begin
            tx_char <= hwdata[DATA_W-1:0];
        end
    end

    assign transmit_enable = control_reg[SSF_CTL_TXEN_BIT];
    assign receive_enable = control_reg[SSF_CTL_RXEN_BIT];
    assign sync_mode = control_reg[SSF_CTL_SYNC_BIT];
    assign two_stop = control_reg[SSF_CTL_TWO_STOP_BIT];

    // ****************************************************************
    // Reception and transmission events
    // ****************************************************************
    // Any error flag stops reception, and transmit in synchronous mode
    assign halt_now = flag[SSF_OVR_IDX] || flag[SSF_FRM_IDX]
        || flag[SSF_PAR_IDX];
    assign tx_stop_now = halt_now && sync_mode;
    assign rx_take = rx_done && receive_enable && !halt_now;
    assign ovr = rx_take && flag[SSF_RXF_IDX];
    assign err_rx = rx_take && !flag[SSF_RXF_IDX]
        && (rx_frame_err || rx_parity_err);
    assign good_rx = rx_take && !flag[SSF_RXF_IDX] && !err_rx;
    assign tx_go = tx_load && !tx_stop_now;

    // Receive buffer keeps old data on overrun
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buffer_reg <= '0;
        end else if (good_rx || err_rx) begin
            rx_buffer_reg <= rx_char;
        end
    end

    // rx_halt mirrors the error flags, tx_halt only in synchronous mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_halt <= 1'b0;
            tx_halt <= 1'b0;
        end else begin
            rx_halt <= halt_now;
            tx_halt <= tx_stop_now;
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // Per-flag set and hardware clear causes
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[SSF_TXE_IDX] = !transmit_enable || tx_go;
        flag_clr[SSF_TXE_IDX] = wr_tx;
        flag_set[SSF_RXF_IDX] = good_rx;
        flag_clr[SSF_RXF_IDX] = rd_rx;
        flag_set[SSF_OVR_IDX] = ovr;
        flag_set[SSF_FRM_IDX] = err_rx && rx_frame_err;
        flag_set[SSF_PAR_IDX] = err_rx && rx_parity_err;
    end

    genvar gi;
    generate
        for (gi = 0; gi < SSF_NUM_FLAGS; gi++) begin : g_flag
            // Zero written to this bit position
            assign wr_zero[gi] = wr_status && !hwdata[SSF_FLAG_BIT[gi]];
            ssf_flag_cell #(
                .RST_VAL(SSF_FLAG_RST[gi])
            ) u_cell (
                .hclk(hclk),
                .hresetn(hresetn),
                .init(low_power_mode),
                .set(flag_set[gi]),
                .hw_clr(flag_clr[gi]),
                .rd_seen(rd_status),
                .wr_any(wr_status),
                .wr_zero(wr_zero[gi]),
                .flag(flag[gi]),
                .set_evt(flag_evt[gi])
            );
            assign status[SSF_FLAG_BIT[gi]] = flag[gi];
            assign evt_vec[SSF_FLAG_BIT[gi]] = flag_evt[gi];
        end
    endgenerate

    // Transmit end clears on a tx buffer write or a zero written over a set empty flag, armed or not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tend_reg <= SSF_TEND_RST;
        end else if (low_power_mode) begin
            tend_reg <= SSF_TEND_RST;
        end else if (!transmit_enable
                     || (tx_last_bit && flag[SSF_TXE_IDX])) begin
            tend_reg <= 1'b1;
        end else if (wr_tx || (wr_zero[SSF_TXE_IDX]
                     && flag[SSF_TXE_IDX])) begin
            tend_reg <= 1'b0;
        end
    end

    assign status[SSF_TEND_BIT] = tend_reg;
    assign status[1:0] = 2'b00;
    assign evt_vec[SSF_TEND_BIT] = 1'b0;
    assign evt_vec[1:0] = 2'b00;

    // ****************************************************************
    // Interrupt status, mask and output
    // ****************************************************************
    // Sticky events, write one to clear, new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= SSF_IRQ_RST;
        end else if (wr_pend_reg && wr_addr_reg == SSF_OFS_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[7:0]) | evt_vec;
        end else begin
            irq_stat_reg <= irq_stat_reg | evt_vec;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= SSF_IRQ_RST;
        end else if (wr_pend_reg && wr_addr_reg == SSF_OFS_IRQ_MASK) begin
            irq_mask_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_low_power_init: assert property (
        @(posedge hclk) disable iff (!hresetn)
        low_power_mode |=> status == SSF_STATUS_RST)
        else $error("status not at reset value after low power");
    chk_txe_disabled: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !transmit_enable |=> flag[SSF_TXE_IDX])
        else $error("tx empty low while transmit disabled");
    chk_txe_clear_cause: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(flag[SSF_TXE_IDX]) |-> $past(wr_tx)
            || $past(wr_zero[SSF_TXE_IDX]))
        else $error("tx empty cleared without cause");
    chk_rxf_set_cause: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(flag[SSF_RXF_IDX]) |-> $past(good_rx))
        else $error("rx full set without clean reception");
    chk_rxf_clear_cause: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(flag[SSF_RXF_IDX]) |-> $past(rd_rx) || $past(wr_status)
            || $past(low_power_mode))
        else $error("rx full cleared without cause");
    chk_rx_disabled_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !receive_enable |=> $stable(rx_buffer_reg))
        else $error("rx buffer changed with receive disabled");
    chk_overrun_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ovr && !low_power_mode |=> $stable(rx_buffer_reg)
            && flag[SSF_OVR_IDX])
        else $error("overrun did not keep old data or set flag");
    chk_halted_rx: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rx_done && flag[SSF_OVR_IDX] |=> $stable(rx_buffer_reg) && rx_halt)
        else $error("reception continued during overrun");
    chk_framing_store: assert property (
        @(posedge hclk) disable iff (!hresetn)
        err_rx && rx_frame_err && !low_power_mode |=>
            rx_buffer_reg == $past(rx_char) && !flag[SSF_RXF_IDX]
            && flag[SSF_FRM_IDX])
        else $error("framing error handling wrong");
    chk_frm_clear_cause: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(flag[SSF_FRM_IDX]) |-> $past(wr_status)
            || $past(low_power_mode))
        else $error("framing flag cleared without status write");

    cov_overrun: cover property (@(posedge hclk) disable iff (!hresetn)
        ovr);
    cov_framing: cover property (@(posedge hclk) disable iff (!hresetn)
        err_rx && rx_frame_err);
    cov_txe_write: cover property (@(posedge hclk) disable iff (!hresetn)
        $fell(flag[SSF_TXE_IDX]));
    cov_irq: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(irq));

endmodule : ssf_status_flags

// ==== ssf_partner.sv ====
// Far-side model: receiver and transmitter shift logic events.
// Assumes its tasks are called just after a rising hclk edge.
`timescale 1ns/1ps
module ssf_partner (
    // Clock
    input wire logic hclk,
    // Receiver events
    output logic rx_done,
    output logic [7:0] rx_char,
    output logic rx_frame_err,
    output logic rx_parity_err,
    // Transmitter events
    output logic tx_load,
    output logic tx_last_bit
);
    // ****************************************************************
    // Event pulses
    // ****************************************************************
    // Pulse lines low at time zero; data and error lines hold noise
    initial begin
        rx_done = 1'b0;
        rx_char = 8'hA5;
        rx_frame_err = 1'b1;
        rx_parity_err = 1'b1;
        tx_load = 1'b0;
        tx_last_bit = 1'b0;
    end

    // One character; data lines turn over once the pulse is gone
    task send_char(input logic [7:0] ch, input logic fe);
        rx_done <= 1'b1;
        rx_char <= ch;
        rx_frame_err <= fe;
        rx_parity_err <= 1'b0;
        @(posedge hclk);
        rx_done <= 1'b0;
        rx_char <= ~ch;
        rx_frame_err <= ~fe;
        rx_parity_err <= 1'b1;
    endtask : send_char

    // Shifter takes the tx buffer and ends the character
    task load_tx();
        tx_load <= 1'b1;
        tx_last_bit <= 1'b1;
        @(posedge hclk);
        tx_load <= 1'b0;
        tx_last_bit <= 1'b0;
    endtask : load_tx
endmodule : ssf_partner

// ==== ssf_status_flags_tb.sv ====
// Self-checking bench for the serial status flag block.
// Assumes hreadyout feeds hready; the far side is ssf_partner.
`timescale 1ns/1ps
module ssf_status_flags_tb;
    import ssf_pkg::*;
    // ****************************************************************
    // Signals, model state and tasks
    // ****************************************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic lpm = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, rx_done, rx_fe, rx_pe, tx_load, tx_lb;
    logic rx_halt, irq;
    logic [7:0] tx_q;
    logic [4:0] ctl_q;
    logic [7:0] rx_char;
    logic [7:0] m_st = 8'h84;
    logic [7:0] m_arm = 8'h00;
    logic [7:0] m_rxb = 8'h00;
    logic [31:0] seed = 32'h63F2E85E;
    logic m_te = 1'b0;
    logic m_re = 1'b0;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;

    always #5 hclk = ~hclk;

    ssf_status_flags i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .low_power_mode(lpm),
        .rx_done(rx_done), .rx_char(rx_char), .rx_frame_err(rx_fe),
        .rx_parity_err(rx_pe), .tx_load(tx_load), .tx_last_bit(tx_lb),
        .tx_char(tx_q), .transmit_enable(ctl_q[2]), .receive_enable(ctl_q[1]),
        .sync_mode(ctl_q[4]), .two_stop(ctl_q[3]), .rx_halt(rx_halt),
        .tx_halt(ctl_q[0]), .irq(irq));

    ssf_partner i_far (.hclk(hclk), .rx_done(rx_done), .rx_char(rx_char),
        .rx_frame_err(rx_fe), .rx_parity_err(rx_pe), .tx_load(tx_load),
        .tx_last_bit(tx_lb));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // One AHB-Lite single transfer; model follows the same access
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        if (!wr && a == SSF_OFS_STATUS) begin
            check(rd & 32'hF8, {24'h0, m_st & 8'hF8});
            m_arm = m_st;
        end else if (!wr && a == SSF_OFS_RX_BUF) begin
            check(rd, {24'h0, m_rxb});
            m_st[6] = 1'b0;
        end else if (!wr) begin
            check(rd, 32'h0);
        end else if (a == SSF_OFS_STATUS) begin
            m_st = m_st & ~(m_arm & ~d[7:0] & 8'hF8);
            m_arm = 8'h00;
        end else if (a == SSF_OFS_CONTROL) begin
            m_te = d[5];
            m_re = d[4];
            m_st[7] = m_st[7] | ~m_te;
        end else if (a == SSF_OFS_TX_BUF) begin
            m_st[7] = m_st[7] & ~m_te;
        end
    endtask : bus

    // Character from the far side, mirrored in the model
    task rx(input logic fe);
        seed = lfsr(seed);
        i_far.send_char(seed[7:0], fe);
        if (m_re && !(m_st[5] | m_st[4] | m_st[3])) begin
            if (m_st[6]) begin
                m_st[5] = 1'b1;
            end else begin
                m_rxb = seed[7:0];
                m_st[6] = !fe;
                m_st[4] = fe;
            end
        end
    endtask : rx

    task final_report();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            final_report();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, SSF_OFS_STATUS, 0);
        bus(1, SSF_OFS_STATUS, 32'hFF);
        bus(0, 8'h20, 0);
        bus(1, SSF_OFS_CONTROL, 32'h30);
        bus(1, SSF_OFS_TX_BUF, 32'h5A);
        bus(0, SSF_OFS_STATUS, 0);
        i_far.load_tx();
        m_st[7] = 1'b1;
        bus(1, SSF_OFS_STATUS, 0);
        bus(0, SSF_OFS_STATUS, 0);
        bus(1, SSF_OFS_STATUS, 32'h7F);
        bus(0, SSF_OFS_STATUS, 0);
        bus(1, SSF_OFS_IRQ_MASK, 32'h40);
        rx(1'b0);
        bus(0, SSF_OFS_STATUS, 0);
        @(posedge hclk); // Irq trails the flag by two registers
        check({31'h0, irq}, 32'h1);
        bus(1, SSF_OFS_IRQ_STAT, 32'h40);
        bus(1, SSF_OFS_IRQ_MASK, 32'h0);
        check({31'h0, irq}, 32'h0);
        rx(1'b0);
        rx(1'b0);
        bus(0, SSF_OFS_STATUS, 0);
        check({31'h0, rx_halt}, 32'h1);
        bus(1, SSF_OFS_CONTROL, 32'hB0);
        i_far.load_tx();
        bus(0, SSF_OFS_STATUS, 0);
        check({19'h0, tx_q, ctl_q}, {19'h0, 8'h5A, 5'h17});
        bus(1, SSF_OFS_CONTROL, 32'h20);
        bus(0, SSF_OFS_STATUS, 0);
        bus(0, SSF_OFS_RX_BUF, 0);
        bus(0, SSF_OFS_STATUS, 0);
        bus(1, SSF_OFS_STATUS, 32'hDF);
        bus(1, SSF_OFS_CONTROL, 32'h30);
        rx(1'b1);
        bus(0, SSF_OFS_STATUS, 0);
        bus(0, SSF_OFS_RX_BUF, 0);
        rx(1'b0);
        bus(1, SSF_OFS_CONTROL, 32'h20);
        bus(0, SSF_OFS_STATUS, 0);
        bus(1, SSF_OFS_STATUS, 32'hEF);
        rx(1'b0);
        bus(0, SSF_OFS_STATUS, 0);
        bus(1, SSF_OFS_CONTROL, 32'h30);
        rx(1'b0);
        lpm <= 1'b1;
        @(posedge hclk);
        lpm <= 1'b0;
        m_st = 8'h84;
        m_arm = 8'h00;
        bus(0, SSF_OFS_STATUS, 0);
        final_report();
    end
endmodule : ssf_status_flags_tb
